/* dfs_consts.svh */
/*
 * register offsets, reset values, command codes and timing figures of the
 * data flash erase/write sequencer.
 * assumes a 40 MHz system clock; included by bare name.
 */
// Functional notes
// R1: area select 0 targets the 1024-byte main data area 0x3C00..0x3FFF.
// R2: area select 1 targets the two 512-byte information pages.
// R3: command code 0x96 launches a page erase of the selected page.
// R4: command code 0x69 programs the write byte into the addressed location.
// R5: byte programming lasts a fixed 23.5 us regardless of erase time.
// R6: firmware loads erase time 0..9; about 5 ms is recommended.
// R7: firmware sets the erase time once at initialisation.
// R8: firmware clears both address registers before a page erase.
// R9: firmware loads address and write byte before a byte write.
// R10: firmware disables interrupts around any erase or write sequence.
// R11: firmware follows each command with four no_operation instructions.
// R12: processor clock is stopped during a page erase until it completes.
// R13: processor clock is stopped during a byte write until it completes.
// R14: each further page erase repeats address setup and reissues the command.
// R15: each further byte write reloads address and data and reissues command.
// R16: firmware clears both address registers after the last operation.
// R17: main area erase takes setting+1 ms plus 0.13 ms, capped at 10.13 ms.
// R18: info page erase takes (setting+1)*0.5 ms plus 0.065 ms, capped 5.065 ms.
// R19: main area logical address 0..1023 maps onto physical 0x3C00..0x3FFF.
// R20: other command codes start nothing and leave array and clock alone.
`ifndef DFS_CONSTS_SVH
`define DFS_CONSTS_SVH

`define DFS_OFS_ADDR_H      8'hF9
`define DFS_OFS_ADDR_L      8'hFA
`define DFS_OFS_WBYTE       8'hFB
`define DFS_OFS_CMD         8'hFC
`define DFS_OFS_TIM         8'hFD
`define DFS_OFS_STATUS      8'hFE
`define DFS_OFS_SEL         8'h20

`define DFS_RST_TIM         8'h5A
`define DFS_CMD_ERASE       8'h96
`define DFS_CMD_PROG        8'h69
`define DFS_TIM_MAX         5'h09

`define DFS_MAIN_BASE       15'h3C00
`define DFS_INFO_A_BASE     15'h4400
`define DFS_INFO_B_OFS      15'h0200
`define DFS_MAIN_TAG        5'h0F
`define DFS_INFO_TAG        5'h11

`define DFS_CLK_NS          25
`define DFS_T_PROG_NS       23500
`define DFS_T_STEP_MAIN_NS  1000000
`define DFS_T_OFS_MAIN_NS   130000
`define DFS_T_STEP_INFO_NS  500000
`define DFS_T_OFS_INFO_NS   65000
`define DFS_CYC(ns)         (((ns) + `DFS_CLK_NS - 1) / `DFS_CLK_NS)

`endif

/* dfs_pkg.sv */
/*
 * types of the data flash erase/write sequencer.
 * assumes nothing beyond the constants header.
 */
package dfs_pkg;

	typedef enum logic [0:0] {ST_IDLE, ST_RUN} dfs_state_t;

	typedef struct packed {
		dfs_state_t  state;
		logic [2:0]  addr_h;
		logic [7:0]  addr_l;
		logic [7:0]  wbyte;
		logic [7:0]  cmd;
		logic [7:0]  tim;
		logic        sel;
		logic [7:0]  rdata;
		logic        erase;
		logic        prog;
		logic        clk_en;
		logic [14:0] faddr;
		logic [7:0]  fdata;
		logic        op_info;
		logic [4:0]  op_tim;
	} dfs_main_t;

endpackage : dfs_pkg

/* dfs_tmr_if.sv */
/*
 * link between the sequencer and its duration timer.
 * assumes both ends share one clock and clock enable.
 */
`timescale 1ns/1ps
interface dfs_tmr_if #(parameter int CNT_W = 20);
	logic             load;
	logic [CNT_W-1:0] count;
	logic             idle;

	modport ctrl (output load, output count, input idle);
	modport tmr  (input load, input count, output idle);
endinterface : dfs_tmr_if

/* dfs_timer.sv */
/*
 * down counter timing one flash operation in system clock cycles.
 * assumes count >= 1 on load; idle rises after exactly count cycles.
 */
`timescale 1ns/1ps
module dfs_timer #(
	parameter int CNT_W = 20
) (
	input  wire logic i_clock,
	input  wire logic i_rst,
	input  wire logic i_ce,
	dfs_tmr_if.tmr    tif
);
	typedef struct packed {
		logic [CNT_W-1:0] cnt;
	} dfs_tmr_st_t;

	dfs_tmr_st_t st_ff;
	dfs_tmr_st_t nxt_st;

	generate
		if (CNT_W < 1) begin : g_bad_width
			$error("dfs_timer: counter width must be at least one bit");
		end
	endgenerate

	always_comb begin
		nxt_st = st_ff;
		if (tif.load) begin
			// loaded one short: the loading cycle itself is the first counted
			nxt_st.cnt = tif.count - CNT_W'(1);
		end else if (st_ff.cnt != '0) begin
			nxt_st.cnt = st_ff.cnt - CNT_W'(1);
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			st_ff <= '0;
		end else if (i_ce) begin
			st_ff <= nxt_st;
		end
	end

	assign tif.idle = (st_ff.cnt == '0);
endmodule : dfs_timer

/* dfs_seq.sv */
/*
 * data flash erase/write sequencer: register port, area and address
 * mapping, command launch, erase/program timing, processor clock gating.
 * assumes a 40 MHz clock, a one-cycle register port, and a flash array that
 * erases or programs while its strobe is high.
 */
`timescale 1ns/1ps
`include "dfs_consts.svh"
module dfs_seq #(
	parameter int CNT_W     = 20,
	parameter int PROG_CYC  = `DFS_CYC(`DFS_T_PROG_NS),
	parameter int STEP_MAIN = `DFS_CYC(`DFS_T_STEP_MAIN_NS),
	parameter int OFS_MAIN  = `DFS_CYC(`DFS_T_OFS_MAIN_NS),
	parameter int STEP_INFO = `DFS_CYC(`DFS_T_STEP_INFO_NS),
	parameter int OFS_INFO  = `DFS_CYC(`DFS_T_OFS_INFO_NS)
) (
	input  wire logic        i_clock,
	input  wire logic        i_rst,
	input  wire logic        i_ce,
	input  wire logic [7:0]  i_addr,
	input  wire logic [7:0]  i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [7:0]  o_rdata,
	output logic      [14:0] o_flash_addr,
	output logic      [7:0]  o_flash_wdata,
	output logic             o_flash_erase,
	output logic             o_flash_prog,
	output logic             o_cpu_clk_en
);
	import dfs_pkg::*;

	localparam int MAX_CYC = 10 * (STEP_MAIN > STEP_INFO ? STEP_MAIN : STEP_INFO)
		+ (OFS_MAIN > OFS_INFO ? OFS_MAIN : OFS_INFO);

	generate
		if (PROG_CYC < 1 || STEP_MAIN < 1 || STEP_INFO < 1 || MAX_CYC >= 2 ** CNT_W
			|| PROG_CYC >= 2 ** CNT_W) begin : g_bad_param
			$error("dfs_seq: timing parameters do not fit the counter");
		end
	endgenerate

	dfs_main_t st_ff;
	dfs_main_t nxt_st;

	dfs_tmr_if #(.CNT_W(CNT_W)) tif ();

	dfs_timer #(.CNT_W(CNT_W)) dfs_timer_inst (
		.i_clock (i_clock),
		.i_rst   (i_rst),
		.i_ce    (i_ce),
		.tif     (tif.tmr)
	);

	always_comb begin
		logic [4:0]  n;
		logic [14:0] phys;
		int          cyc;
		n    = '0;
		phys = '0;
		cyc  = 0;
		nxt_st       = st_ff;
		nxt_st.rdata = '0;
		tif.load     = 1'b0;
		tif.count    = '0;

		// read data stand for the single cycle after the strobe
		if (i_rd) begin
			case (i_addr)
				`DFS_OFS_ADDR_H: nxt_st.rdata = {5'h00, st_ff.addr_h};
				`DFS_OFS_ADDR_L: nxt_st.rdata = st_ff.addr_l;
				`DFS_OFS_WBYTE:  nxt_st.rdata = st_ff.wbyte;
				`DFS_OFS_CMD:    nxt_st.rdata = st_ff.cmd;
				`DFS_OFS_TIM:    nxt_st.rdata = st_ff.tim;
				`DFS_OFS_SEL:    nxt_st.rdata = {7'h00, st_ff.sel};
				`DFS_OFS_STATUS: nxt_st.rdata = {7'h00, st_ff.state == ST_RUN};
				default:         nxt_st.rdata = '0;
			endcase
		end

		if (i_wr) begin
			case (i_addr)
				`DFS_OFS_ADDR_H: nxt_st.addr_h = i_wdata[2:0];
				`DFS_OFS_ADDR_L: nxt_st.addr_l = i_wdata;
				`DFS_OFS_WBYTE:  nxt_st.wbyte  = i_wdata;
				`DFS_OFS_CMD:    nxt_st.cmd    = i_wdata;
				`DFS_OFS_TIM:    nxt_st.tim    = i_wdata;
				`DFS_OFS_SEL:    nxt_st.sel    = i_wdata[0];
				default:         nxt_st.sel    = st_ff.sel;
			endcase
		end

		// only bits 4:0 of the setting count; values above the table top saturate at the longest erase
		n = (st_ff.tim[4:0] > `DFS_TIM_MAX) ? `DFS_TIM_MAX : st_ff.tim[4:0]; // R17 R18
		if (st_ff.sel) begin
			phys = `DFS_INFO_A_BASE + (st_ff.addr_h[2] ? `DFS_INFO_B_OFS : 15'h0000)
				+ {6'h00, st_ff.addr_h[0], st_ff.addr_l}; // R2
			cyc  = (int'(n) + 1) * STEP_INFO + OFS_INFO; // R18
		end else begin
			phys = `DFS_MAIN_BASE + {5'h00, st_ff.addr_h[1:0], st_ff.addr_l}; // R1 R19
			cyc  = (int'(n) + 1) * STEP_MAIN + OFS_MAIN; // R17
		end

		case (st_ff.state)
			ST_IDLE: begin
				// other command codes only store; nothing is launched
				if (i_wr && i_addr == `DFS_OFS_CMD
					&& (i_wdata == `DFS_CMD_ERASE || i_wdata == `DFS_CMD_PROG)) begin // R20
					nxt_st.state   = ST_RUN;
					nxt_st.clk_en  = 1'b0; // R12 R13
					nxt_st.faddr   = phys;
					nxt_st.fdata   = st_ff.wbyte;
					nxt_st.op_info = st_ff.sel;
					nxt_st.op_tim  = n;
					tif.load       = 1'b1;
					if (i_wdata == `DFS_CMD_ERASE) begin
						nxt_st.erase = 1'b1; // R3
						tif.count    = CNT_W'(cyc);
					end else begin
						nxt_st.prog  = 1'b1; // R4
						tif.count    = CNT_W'(PROG_CYC); // R5
					end
				end
			end
			ST_RUN: begin
				// the processor clock returns only with the array released
				if (tif.idle) begin
					nxt_st.state  = ST_IDLE;
					nxt_st.erase  = 1'b0;
					nxt_st.prog   = 1'b0;
					nxt_st.clk_en = 1'b1; // R12 R13
				end
			end
			default: nxt_st.state = ST_IDLE;
		endcase
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			st_ff        <= '0;
			st_ff.tim    <= `DFS_RST_TIM;
			st_ff.clk_en <= 1'b1;
		end else if (i_ce) begin
			st_ff <= nxt_st;
		end
	end

	assign o_rdata       = st_ff.rdata;
	assign o_flash_addr  = st_ff.faddr;
	assign o_flash_wdata = st_ff.fdata;
	assign o_flash_erase = st_ff.erase;
	assign o_flash_prog  = st_ff.prog;
	assign o_cpu_clk_en  = st_ff.clk_en;

	// assertion helpers: active length counted in enabled cycles
	logic [CNT_W-1:0] len_ff;
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			len_ff <= '0;
		end else if (i_ce) begin
			len_ff <= (st_ff.erase || st_ff.prog) ? len_ff + CNT_W'(1) : '0;
		end
	end

	function automatic int erase_len(input logic info, input logic [4:0] t);
		erase_len = info ? (int'(t) + 1) * STEP_INFO + OFS_INFO
			: (int'(t) + 1) * STEP_MAIN + OFS_MAIN;
	endfunction : erase_len

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);

	a_main_addr_range: assert property ( // R1
		(st_ff.erase || st_ff.prog) && !st_ff.op_info
		|-> o_flash_addr[14:10] == `DFS_MAIN_TAG)
		else $error("main area operation outside main data range");
	a_info_addr_range: assert property ( // R2
		(st_ff.erase || st_ff.prog) && st_ff.op_info
		|-> o_flash_addr[14:10] == `DFS_INFO_TAG)
		else $error("info page operation outside info page range");
	a_erase_launch: assert property ( // R3
		i_ce && i_wr && i_addr == `DFS_OFS_CMD && i_wdata == `DFS_CMD_ERASE
		&& st_ff.state == ST_IDLE
		|=> o_flash_erase && !o_flash_prog && !o_cpu_clk_en)
		else $error("erase command did not start an erase");
	a_prog_launch: assert property ( // R4
		i_ce && i_wr && i_addr == `DFS_OFS_CMD && i_wdata == `DFS_CMD_PROG
		&& st_ff.state == ST_IDLE
		|=> o_flash_prog && o_flash_wdata == $past(st_ff.wbyte))
		else $error("program command did not start programming");
	a_prog_length: assert property ( // R5
		$fell(o_flash_prog) |-> $past(len_ff) == CNT_W'(PROG_CYC - 1))
		else $error("byte program length wrong");
	a_erase_length: assert property ( // R17 R18
		$fell(o_flash_erase)
		|-> $past(len_ff) == CNT_W'(erase_len(st_ff.op_info, st_ff.op_tim) - 1))
		else $error("page erase length wrong");
	a_erase_clk_off: assert property (o_flash_erase |-> !o_cpu_clk_en) // R12
		else $error("processor clock running during erase");
	a_prog_clk_off: assert property (o_flash_prog |-> !o_cpu_clk_en) // R13
		else $error("processor clock running during programming");
	a_clk_back: assert property ( // R12 R13
		$fell(o_flash_erase) || $fell(o_flash_prog) |-> o_cpu_clk_en)
		else $error("processor clock not restored after operation");
	a_bad_cmd_quiet: assert property ( // R20
		i_ce && i_wr && i_addr == `DFS_OFS_CMD && i_wdata != `DFS_CMD_ERASE
		&& i_wdata != `DFS_CMD_PROG && st_ff.state == ST_IDLE
		|=> !o_flash_erase && !o_flash_prog && o_cpu_clk_en)
		else $error("unknown command disturbed array or clock");
	// judged against the capped length, not the stored setting, so a broken cap shows
	a_tim_saturate: assert property ( // R17 R18
		$fell(o_flash_erase)
		|-> $past(len_ff) <= CNT_W'(erase_len(st_ff.op_info, `DFS_TIM_MAX) - 1))
		else $error("erase longer than the capped setting allows");

	c_main_erase: cover property ($fell(o_flash_erase) && !st_ff.op_info);
	c_info_erase: cover property ($fell(o_flash_erase) && st_ff.op_info);
	c_byte_prog:  cover property ($fell(o_flash_prog));
	c_bad_cmd:    cover property (i_ce && i_wr && i_addr == `DFS_OFS_CMD
		&& i_wdata != `DFS_CMD_ERASE && i_wdata != `DFS_CMD_PROG && st_ff.state == ST_IDLE);
	c_busy_cmd:   cover property (i_ce && i_wr && i_addr == `DFS_OFS_CMD
		&& st_ff.state == ST_RUN);
endmodule : dfs_seq

/* dfs_tb.sv */
/*
 * self-checking testbench of the data flash erase/write sequencer: register
 * reset values and readback, area and address mapping, strobe lengths and
 * processor clock gating, unknown command codes, busy behaviour, clock
 * enable freeze and a reset in mid-operation.
 * assumes dfs_seq with shortened timing parameters.
 */
`timescale 1ns/1ps
`include "dfs_consts.svh"
module testbench;
	import dfs_pkg::*;

	localparam int P_CYC  = 5;
	localparam int S_MAIN = 20;
	localparam int O_MAIN = 3;
	localparam int S_INFO = 10;
	localparam int O_INFO = 2;

	logic        i_clock;
	logic        i_rst;
	logic        i_ce;
	logic [7:0]  i_addr;
	logic [7:0]  i_wdata;
	logic        i_wr;
	logic        i_rd;
	logic [7:0]  o_rdata;
	logic [14:0] o_flash_addr;
	logic [7:0]  o_flash_wdata;
	logic        o_flash_erase;
	logic        o_flash_prog;
	logic        o_cpu_clk_en;
	int          num_errors;
	int          checked;
	int          op_cycles;

	dfs_seq #(.PROG_CYC(P_CYC), .STEP_MAIN(S_MAIN), .OFS_MAIN(O_MAIN),
		.STEP_INFO(S_INFO), .OFS_INFO(O_INFO)) dfs_seq_inst (
		.i_clock       (i_clock),
		.i_rst         (i_rst),
		.i_ce          (i_ce),
		.i_addr        (i_addr),
		.i_wdata       (i_wdata),
		.i_wr          (i_wr),
		.i_rd          (i_rd),
		.o_rdata       (o_rdata),
		.o_flash_addr  (o_flash_addr),
		.o_flash_wdata (o_flash_wdata),
		.o_flash_erase (o_flash_erase),
		.o_flash_prog  (o_flash_prog),
		.o_cpu_clk_en  (o_cpu_clk_en)
	);

	initial begin
		i_clock = 1'b0;
		forever #12.5 i_clock = ~i_clock;
	end

	task automatic finish_test();
		$display("compares %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : finish_test

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clock);
		i_wr    <= 1'b1;
		i_addr  <= a;
		i_wdata <= d;
		@(posedge i_clock);
		i_wr <= 1'b0;
		#1;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge i_clock);
		i_rd   <= 1'b1;
		i_addr <= a;
		@(posedge i_clock);
		i_rd <= 1'b0;
		#1;
		chk({8'h00, o_rdata}, {8'h00, exp});
	endtask : rd

	// launches a command and measures how many cycles its strobe stands
	task automatic run_op(input logic [7:0] c, input int n, input logic [14:0] a,
		input logic [7:0] d);
		int cnt;
		wr(`DFS_OFS_CMD, c);
		chk({1'b0, o_flash_addr}, {1'b0, a});
		chk({15'h0000, o_cpu_clk_en}, 16'h0000);
		if (c == `DFS_CMD_PROG) begin
			chk({8'h00, o_flash_wdata}, {8'h00, d});
		end
		count_op(c == `DFS_CMD_ERASE, cnt);
		chk(cnt[15:0], n[15:0]);
		chk({13'h0000, o_cpu_clk_en, o_flash_erase, o_flash_prog}, 16'h0004);
	endtask : run_op

	// counts the cycles a strobe still stands; the bus stays quiet meanwhile
	task automatic count_op(input logic er, output int cnt);
		cnt = 0;
		while ((er ? o_flash_erase : o_flash_prog) === 1'b1) begin
			cnt++;
			if (cnt > 1000) begin
				num_errors++;
				$display("unexpected at %0t: got %h expected %h", $time, cnt, 1000);
				finish_test();
			end
			@(posedge i_clock);
			#1;
		end
	endtask : count_op

	// unmapped 0x10 reads as zero
	logic [7:0] reg_a [8] = '{8'hF9, 8'hFA, 8'hFB, 8'hFC, 8'hFD, 8'h20, 8'hFE, 8'h10};
	logic [7:0] reg_v [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h5A, 8'h00, 8'h00, 8'h00};

	initial begin
		i_rst      = 1'b1;
		i_ce       = 1'b1;
		i_addr     = 8'h00;
		i_wdata    = 8'h00;
		i_wr       = 1'b0;
		i_rd       = 1'b0;
		num_errors = 0;
		checked    = 0;
		repeat (6) @(posedge i_clock);
		i_rst <= 1'b0;
		#1;
		chk({13'h0000, o_cpu_clk_en, o_flash_erase, o_flash_prog}, 16'h0004);
		for (int i = 0; i < 8; i++) begin
			rd(reg_a[i], reg_v[i]);
		end
		wr(`DFS_OFS_ADDR_H, 8'hFF);
		rd(`DFS_OFS_ADDR_H, 8'h07);
		wr(`DFS_OFS_SEL, 8'hFF);
		rd(`DFS_OFS_SEL, 8'h01);
		$display("test registers done");

		// main area program, addr_h bit2 must not reach the address
		wr(`DFS_OFS_SEL, 8'h00);
		wr(`DFS_OFS_ADDR_H, 8'h07);
		wr(`DFS_OFS_ADDR_L, 8'h45);
		wr(`DFS_OFS_WBYTE, 8'hA5);
		run_op(`DFS_CMD_PROG, P_CYC, `DFS_MAIN_BASE + 15'h0345, 8'hA5);
		// back to back: second byte with a new address, erase time ignored
		wr(`DFS_OFS_TIM, 8'h09);
		wr(`DFS_OFS_ADDR_H, 8'h00);
		wr(`DFS_OFS_ADDR_L, 8'h00);
		wr(`DFS_OFS_WBYTE, 8'h3C);
		run_op(`DFS_CMD_PROG, P_CYC, `DFS_MAIN_BASE, 8'h3C);
		$display("test main program done");

		// second information page, addr_h bit1 ignored
		wr(`DFS_OFS_SEL, 8'h01);
		wr(`DFS_OFS_ADDR_H, 8'h07);
		wr(`DFS_OFS_ADDR_L, 8'h10);
		wr(`DFS_OFS_WBYTE, 8'h5A);
		run_op(`DFS_CMD_PROG, P_CYC, `DFS_INFO_A_BASE + `DFS_INFO_B_OFS + 15'h0110, 8'h5A);
		$display("test info program done");

		// erase lengths: shortest, capped setting with upper bits set, info page
		wr(`DFS_OFS_SEL, 8'h00);
		wr(`DFS_OFS_TIM, 8'h00);
		wr(`DFS_OFS_ADDR_H, 8'h00);
		wr(`DFS_OFS_ADDR_L, 8'h00);
		run_op(`DFS_CMD_ERASE, S_MAIN + O_MAIN, `DFS_MAIN_BASE, 8'h00);
		wr(`DFS_OFS_TIM, 8'hEC);
		run_op(`DFS_CMD_ERASE, 10 * S_MAIN + O_MAIN, `DFS_MAIN_BASE, 8'h00);
		wr(`DFS_OFS_SEL, 8'h01);
		wr(`DFS_OFS_TIM, 8'h02);
		wr(`DFS_OFS_ADDR_H, 8'h02);
		run_op(`DFS_CMD_ERASE, 3 * S_INFO + O_INFO, `DFS_INFO_A_BASE, 8'h00);
		wr(`DFS_OFS_TIM, 8'h1F);
		wr(`DFS_OFS_ADDR_H, 8'h04);
		run_op(`DFS_CMD_ERASE, 10 * S_INFO + O_INFO,
			`DFS_INFO_A_BASE + `DFS_INFO_B_OFS, 8'h00);
		$display("test erase done");

		// unknown codes are stored but start nothing
		wr(`DFS_OFS_CMD, 8'h55);
		repeat (3) begin
			chk({13'h0000, o_cpu_clk_en, o_flash_erase, o_flash_prog}, 16'h0004);
			@(posedge i_clock);
			#1;
		end
		rd(`DFS_OFS_CMD, 8'h55);
		rd(`DFS_OFS_STATUS, 8'h00);
		$display("test unknown command done");

		// busy: status, a command that must not launch, frozen clock enable
		wr(`DFS_OFS_SEL, 8'h00);
		wr(`DFS_OFS_TIM, 8'h00);
		wr(`DFS_OFS_ADDR_H, 8'h00);
		wr(`DFS_OFS_CMD, `DFS_CMD_ERASE);
		rd(`DFS_OFS_STATUS, 8'h01);
		wr(`DFS_OFS_CMD, `DFS_CMD_PROG);
		chk({13'h0000, o_cpu_clk_en, o_flash_erase, o_flash_prog}, 16'h0002);
		@(posedge i_clock);
		i_ce <= 1'b0;
		repeat (4) @(posedge i_clock);
		i_ce <= 1'b1;
		#1;
		chk({13'h0000, o_cpu_clk_en, o_flash_erase, o_flash_prog}, 16'h0002);
		// five enabled cycles passed before the freeze
		count_op(1'b1, op_cycles);
		chk(op_cycles[15:0], 16'(S_MAIN + O_MAIN - 5));
		chk({13'h0000, o_cpu_clk_en, o_flash_erase, o_flash_prog}, 16'h0004);
		wr(`DFS_OFS_ADDR_L, 8'h00);
		wr(`DFS_OFS_ADDR_H, 8'h00);
		$display("test busy done");

		// reset in mid-program: strobe drops and the clock gate opens at once
		wr(`DFS_OFS_CMD, `DFS_CMD_PROG);
		chk({13'h0000, o_cpu_clk_en, o_flash_erase, o_flash_prog}, 16'h0001);
		@(posedge i_clock);
		i_rst <= 1'b1;
		#1;
		chk({13'h0000, o_cpu_clk_en, o_flash_erase, o_flash_prog}, 16'h0004);
		repeat (2) @(posedge i_clock);
		i_rst <= 1'b0;
		#1;
		chk({13'h0000, o_cpu_clk_en, o_flash_erase, o_flash_prog}, 16'h0004);
		rd(`DFS_OFS_TIM, 8'h5A);
		rd(`DFS_OFS_STATUS, 8'h00);
		$display("test reset done");
		finish_test();
	end
endmodule : testbench
